// File: hw/fpc_pkg.sv
// Constants shared by the fractional clock multiplier configuration block
// Overview of operation
// - Reference clock passes through a selectable divide-by-one or divide-by-two prescaler.
// - Oscillator output divides by four, or by two when half-output-divide is set.
// - A programmable integer master prescaler after the output scaler makes the master clock.
// - Fraction is 24-bit unsigned, fraction times 2^24 rounded; ratio is N plus K/2^24.
// - Integer part and prescaler select share the prescale/integer register.
// - Fraction splits: top 6 bits, middle 9 bits, low 9 bits over three registers.
// - Select pin can carry the master prescaler input clock divided by 1, 2, 3 or 4.
// - Master prescaler is fed from the reference pin or the oscillator path by selection.
package fpc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam logic [ADDR_W-1:0] PRESCALE_INT_ADDR = 7'h24;
    localparam logic [ADDR_W-1:0] FRAC_HIGH_ADDR = 7'h25;
    localparam logic [ADDR_W-1:0] FRAC_MID_ADDR = 7'h26;
    localparam logic [ADDR_W-1:0] FRAC_LOW_ADDR = 7'h27;
    localparam logic [DATA_W-1:0] PRESCALE_INT_RST = 9'h008;
    localparam logic [DATA_W-1:0] FRAC_HIGH_RST = 9'h000;
    localparam logic [DATA_W-1:0] FRAC_MID_RST = 9'h000;
    localparam logic [DATA_W-1:0] FRAC_LOW_RST = 9'h000;
    localparam logic [DATA_W-1:0] READ_NONE = 9'h000;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int INT_W = 4;
    localparam int INT_LSB = 0;
    localparam int PRESEL_BIT = 4;
    localparam int FRAC_W = 24;
    localparam int FRAC_HIGH_W = 6;
    localparam int FRAC_PART_W = 9;

    // ------------------------------------------------------------------
    // Divider constants
    // ------------------------------------------------------------------
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [DIV_W-1:0] DIV_TWO = 8'h02;
    localparam logic [DIV_W-1:0] DIV_FOUR = 8'h04;
    localparam int GPIO_SEL_W = 2;
endpackage

// File: hw/fpc_div_if.sv
// Clock divider connection: input edge stream, divisor and divided clock
`timescale 1ns/1ns
interface fpc_div_if;
    import fpc_pkg::*;
    logic in_level;
    logic in_rise;
    logic [DIV_W-1:0] divisor;
    logic out_level;
    logic out_rise;
    modport src (output in_level, output in_rise, output divisor, input out_level, input out_rise);
    modport div (input in_level, input in_rise, input divisor, output out_level, output out_rise);
endinterface

// File: hw/fpc_divider.sv
// Integer clock divider working on rising-edge strobes of a sampled clock
`timescale 1ns/1ns
module fpc_divider (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Divider link
    fpc_div_if.div dv
);
    import fpc_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic level_reg;
    logic level_next;
    logic rise_reg;
    wire logic [DIV_W-1:0] div_eff = (dv.divisor == '0) ? DIV_ONE : dv.divisor;
    wire logic [DIV_W-1:0] half = DIV_W'((div_eff + DIV_ONE) >> 1);
    wire logic wrap = (cnt_reg >= div_eff - DIV_ONE);
    wire logic pass = (div_eff == DIV_ONE);

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    // Output is high for the first half of each period, low for the rest;
    // odd divisors therefore give a duty a little above one half.
    always_comb begin
        cnt_next = cnt_reg;
        level_next = level_reg;
        if (pass) begin
            cnt_next = '0;
            level_next = dv.in_level;
        end else if (dv.in_rise) begin
            cnt_next = wrap ? '0 : cnt_reg + DIV_ONE;
            level_next = (cnt_next < half);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            level_reg <= level_next;
            rise_reg <= dv.in_rise && (pass || wrap);
        end
    end

    assign dv.out_level = level_reg;
    assign dv.out_rise = rise_reg;
endmodule

// File: hw/fpc_clock_config.sv
// Fractional clock multiplier configuration registers and divider chain
`timescale 1ns/1ns
module fpc_clock_config (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port from the serial control interface
    input wire logic reg_wr_en,
    input wire logic [fpc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fpc_pkg::DATA_W-1:0] reg_wr_data,
    output logic [fpc_pkg::DATA_W-1:0] reg_rd_data,
    // Clock control settings held elsewhere
    input wire logic pll_enable,
    input wire logic pll_half_output_divide,
    input wire logic clock_select_pll,
    input wire logic [fpc_pkg::DIV_W-1:0] master_prescale,
    input wire logic gpio_pll_output_enable,
    input wire logic [fpc_pkg::GPIO_SEL_W-1:0] gpio_divide_select,
    // Clocks sampled from pins and from the oscillator
    input wire logic mclk_pin,
    input wire logic pll_osc_level,
    // Oscillator loop control
    output logic pll_osc_enable,
    output logic pll_ref_clk,
    output logic [fpc_pkg::INT_W-1:0] pll_ratio_int,
    output logic [fpc_pkg::FRAC_W-1:0] pll_ratio_frac,
    // Clock outputs
    output logic internal_master_clock,
    output logic multipurpose_select_pin_out,
    output logic multipurpose_select_pin_oe_n
);
    import fpc_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic rising(input logic now, input logic prev);
        rising = now & ~prev;
    endfunction

    function automatic logic [DIV_W-1:0] gpio_divisor(input logic [GPIO_SEL_W-1:0] sel);
        gpio_divisor = DIV_W'(sel) + DIV_ONE;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] prescale_int_reg;
    logic [DATA_W-1:0] frac_high_reg;
    logic [DATA_W-1:0] frac_mid_reg;
    logic [DATA_W-1:0] frac_low_reg;
    logic [DATA_W-1:0] rd_next;
    logic [INT_W-1:0] applied_int_reg;
    logic [FRAC_W-1:0] applied_frac_reg;
    logic pll_en_reg;
    logic mclk_prev_reg;
    logic osc_prev_reg;

    wire logic wr_prescale_int = reg_wr_en && (reg_addr == PRESCALE_INT_ADDR);
    wire logic wr_frac_high = reg_wr_en && (reg_addr == FRAC_HIGH_ADDR);
    wire logic wr_frac_mid = reg_wr_en && (reg_addr == FRAC_MID_ADDR);
    wire logic wr_frac_low = reg_wr_en && (reg_addr == FRAC_LOW_ADDR);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prescale_int_reg <= PRESCALE_INT_RST;
            frac_high_reg <= FRAC_HIGH_RST;
            frac_mid_reg <= FRAC_MID_RST;
            frac_low_reg <= FRAC_LOW_RST;
        end else begin
            if (wr_prescale_int) begin
                prescale_int_reg <= reg_wr_data;
            end
            if (wr_frac_high) begin
                frac_high_reg <= reg_wr_data;
            end
            if (wr_frac_mid) begin
                frac_mid_reg <= reg_wr_data;
            end
            if (wr_frac_low) begin
                frac_low_reg <= reg_wr_data;
            end
        end
    end

    // Unused upper bits of the high fraction register read back as written
    always_comb begin
        case (reg_addr)
            PRESCALE_INT_ADDR: rd_next = prescale_int_reg;
            FRAC_HIGH_ADDR: rd_next = frac_high_reg;
            FRAC_MID_ADDR: rd_next = frac_mid_reg;
            FRAC_LOW_ADDR: rd_next = frac_low_reg;
            default: rd_next = READ_NONE;
        endcase
    end

    // ------------------------------------------------------------------
    // Multiplier ratio handed to the oscillator loop
    // ------------------------------------------------------------------
    wire logic [INT_W-1:0] prog_int = prescale_int_reg[INT_LSB +: INT_W];
    wire logic [FRAC_W-1:0] prog_frac = {frac_high_reg[FRAC_HIGH_W-1:0],
        frac_mid_reg[FRAC_PART_W-1:0], frac_low_reg[FRAC_PART_W-1:0]};
    wire logic pll_en_rise = rising(pll_enable, pll_en_reg);

    // Ratio is captured only on the enable edge, so register-by-register
    // writes while running cannot step the loop through odd frequencies.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pll_en_reg <= 1'b0;
            applied_int_reg <= PRESCALE_INT_RST[INT_LSB +: INT_W];
            applied_frac_reg <= '0;
        end else begin
            pll_en_reg <= pll_enable;
            if (pll_en_rise) begin
                applied_int_reg <= prog_int;
                applied_frac_reg <= prog_frac;
            end
        end
    end

    // ------------------------------------------------------------------
    // Divider chain
    // ------------------------------------------------------------------
    fpc_div_if pre_if ();
    fpc_div_if post_if ();
    fpc_div_if mclk_if ();
    fpc_div_if gpio_if ();

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mclk_prev_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            mclk_prev_reg <= mclk_pin;
            osc_prev_reg <= pll_osc_level & pll_en_reg;
        end
    end

    wire logic mclk_rise = rising(mclk_pin, mclk_prev_reg);
    wire logic osc_gated = pll_osc_level & pll_en_reg;
    wire logic osc_rise = rising(osc_gated, osc_prev_reg);

    assign pre_if.in_level = mclk_pin;
    assign pre_if.in_rise = mclk_rise;
    assign pre_if.divisor = prescale_int_reg[PRESEL_BIT] ? DIV_TWO : DIV_ONE;

    assign post_if.in_level = osc_gated;
    assign post_if.in_rise = osc_rise;
    assign post_if.divisor = pll_half_output_divide ? DIV_TWO : DIV_FOUR;

    // Master prescaler input: reference pin or scaled oscillator
    wire logic src_level = clock_select_pll ? post_if.out_level : mclk_pin;
    wire logic src_rise = clock_select_pll ? post_if.out_rise : mclk_rise;

    assign mclk_if.in_level = src_level;
    assign mclk_if.in_rise = src_rise;
    assign mclk_if.divisor = master_prescale;

    assign gpio_if.in_level = src_level;
    assign gpio_if.in_rise = src_rise;
    assign gpio_if.divisor = gpio_divisor(gpio_divide_select);

    fpc_divider u_pre (.clk_sys(clk_sys), .sys_rst(sys_rst), .dv(pre_if));
    fpc_divider u_post (.clk_sys(clk_sys), .sys_rst(sys_rst), .dv(post_if));
    fpc_divider u_mclk (.clk_sys(clk_sys), .sys_rst(sys_rst), .dv(mclk_if));
    fpc_divider u_gpio (.clk_sys(clk_sys), .sys_rst(sys_rst), .dv(gpio_if));

    // ------------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rd_data <= READ_NONE;
            pll_osc_enable <= 1'b0;
            pll_ref_clk <= 1'b0;
            pll_ratio_int <= PRESCALE_INT_RST[INT_LSB +: INT_W];
            pll_ratio_frac <= '0;
            internal_master_clock <= 1'b0;
            multipurpose_select_pin_out <= 1'b0;
            multipurpose_select_pin_oe_n <= 1'b1;
        end else begin
            reg_rd_data <= rd_next;
            pll_osc_enable <= pll_en_reg;
            pll_ref_clk <= pre_if.out_level;
            pll_ratio_int <= applied_int_reg;
            pll_ratio_frac <= applied_frac_reg;
            internal_master_clock <= mclk_if.out_level;
            multipurpose_select_pin_out <= gpio_pll_output_enable & gpio_if.out_level;
            multipurpose_select_pin_oe_n <= ~gpio_pll_output_enable;
        end
    end
endmodule

// File: tb/fpc_clock_config_chk.sv
// Assertion checker for the clock configuration block
`timescale 1ns/1ns
module fpc_clock_config_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_wr_en,
    input wire logic [fpc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fpc_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic [fpc_pkg::DATA_W-1:0] reg_rd_data,
    // Settings and outputs
    input wire logic pll_enable,
    input wire logic pll_osc_enable,
    input wire logic [fpc_pkg::INT_W-1:0] pll_ratio_int,
    input wire logic [fpc_pkg::FRAC_W-1:0] pll_ratio_frac,
    input wire logic mclk_pin,
    input wire logic pll_ref_clk,
    input wire logic clock_select_pll,
    input wire logic internal_master_clock,
    input wire logic gpio_pll_output_enable,
    input wire logic multipurpose_select_pin_out,
    input wire logic multipurpose_select_pin_oe_n
);
    import fpc_pkg::*;
    // Shadow of the four multiplier registers, rebuilt from the write strobes
    logic [DATA_W-1:0] sh [4];
    wire hit = reg_addr[6:2] == 5'h09;
    wire [DATA_W-1:0] sel_val = hit ? sh[reg_addr[1:0]] : READ_NONE;
    wire [FRAC_W-1:0] sh_frac = {sh[1][5:0], sh[2], sh[3]};
    wire [INT_W-1:0] sh_int = sh[0][3:0];
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sh <= '{PRESCALE_INT_RST, FRAC_HIGH_RST, FRAC_MID_RST, FRAC_LOW_RST};
        end else if (reg_wr_en && hit) begin
            sh[reg_addr[1:0]] <= reg_wr_data;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_en_rise;
        $rose(pll_enable);
    endsequence
    sequence s_no_rise2;
        !$rose(pll_enable) ##1 !$rose(pll_enable);
    endsequence
    AST_OSC_ON: assert property (s_en_rise |-> ##2 pll_osc_enable)
        else $error("oscillator enable not raised two cycles after enable");
    AST_OSC_OFF: assert property ($fell(pll_enable) |-> ##2 !pll_osc_enable)
        else $error("oscillator enable not dropped two cycles after disable");
    AST_RATIO_SET: assert property (s_en_rise |-> ##2 pll_ratio_frac == $past(sh_frac, 2)
        && pll_ratio_int == $past(sh_int, 2))
        else $error("applied ratio differs from programmed registers");
    AST_RATIO_HOLD: assert property (s_no_rise2 |=> $stable(pll_ratio_frac)
        && $stable(pll_ratio_int))
        else $error("applied ratio changed without an enable edge");
    AST_RD_DATA: assert property (1'b1 |=> reg_rd_data == $past(sel_val))
        else $error("read data differs from register contents");
    AST_PIN_OE: assert property (1'b1 |=>
        multipurpose_select_pin_oe_n == !$past(gpio_pll_output_enable))
        else $error("select pin enable does not follow its setting");
    AST_PIN_QUIET: assert property (!gpio_pll_output_enable |=> !multipurpose_select_pin_out)
        else $error("select pin toggles while not enabled");
    // Pin edge reaches the output after the divider flop and the output flop
    AST_REF_RISE: assert property ($rose(pll_ref_clk) |-> $past(mclk_pin, 2)
        && !$past(mclk_pin, 3))
        else $error("reference prescaler rose without a reference edge");
    AST_GATED: assert property ((clock_select_pll && !pll_osc_enable) [*8] |->
        $stable(internal_master_clock))
        else $error("master clock runs from a stopped oscillator");
endmodule
bind fpc_clock_config fpc_clock_config_chk fpc_clock_config_chk_i (.clk_sys, .sys_rst,
    .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data, .pll_enable, .pll_osc_enable,
    .pll_ratio_int, .pll_ratio_frac, .mclk_pin, .pll_ref_clk, .clock_select_pll,
    .internal_master_clock, .gpio_pll_output_enable, .multipurpose_select_pin_out,
    .multipurpose_select_pin_oe_n);

// File: tb/fpc_ref_src.sv
// Reference clock source and sampled oscillator model
`timescale 1ns/1ns
module fpc_ref_src (
    // Clock
    input wire logic clk_sys,
    // Oscillator run request
    input wire logic osc_run,
    // Clock levels
    output logic mclk_pin,
    output logic pll_osc_level
);
    logic [1:0] cnt;
    initial begin
        cnt = 2'h0;
        mclk_pin = 1'b0;
        pll_osc_level = 1'b0;
    end
    // Reference period is four system cycles, oscillator period two
    always @(posedge clk_sys) begin
        cnt <= cnt + 2'h1;
        mclk_pin <= cnt[1];
        // A stopped oscillator keeps toggling so that gating inside is really tested
        pll_osc_level <= osc_run ? cnt[0] : ~pll_osc_level;
    end
endmodule

// File: tb/test_fpc_clock_config.sv
// Self-checking testbench for the clock configuration block
`timescale 1ns/1ns
module test_fpc_clock_config;
    import fpc_pkg::*;
    logic clk_sys, sys_rst, reg_wr_en, pll_enable, pll_half_output_divide, clock_select_pll;
    logic gpio_pll_output_enable, mclk_pin, pll_osc_level, pll_osc_enable, pll_ref_clk;
    logic internal_master_clock, multipurpose_select_pin_out, multipurpose_select_pin_oe_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wr_data, reg_rd_data;
    logic [DIV_W-1:0] master_prescale;
    logic [GPIO_SEL_W-1:0] gpio_divide_select;
    logic [INT_W-1:0] pll_ratio_int;
    logic [FRAC_W-1:0] pll_ratio_frac;
    int mismatches = 0;
    int n_checks = 0;
    int i;
    fpc_clock_config fpc_clock_config_i (.clk_sys, .sys_rst, .reg_wr_en, .reg_addr,
        .reg_wr_data, .reg_rd_data, .pll_enable, .pll_half_output_divide, .clock_select_pll,
        .master_prescale, .gpio_pll_output_enable, .gpio_divide_select, .mclk_pin,
        .pll_osc_level, .pll_osc_enable, .pll_ref_clk, .pll_ratio_int, .pll_ratio_frac,
        .internal_master_clock, .multipurpose_select_pin_out, .multipurpose_select_pin_oe_n);
    fpc_ref_src fpc_ref_src_i (.clk_sys, .osc_run(pll_osc_enable), .mclk_pin, .pll_osc_level);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic sig(input int s);
        case (s)
            0: sig = pll_ref_clk;
            1: sig = internal_master_clock;
            default: sig = multipurpose_select_pin_out;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("reg_rd_data", {23'h0, reg_rd_data}, {23'h0, e});
    endtask
    // Period of a clock output, taken between its third and second rise after settling
    task automatic per(input int s, input int e);
        int k, t0, n, p;
        logic prv, cur;
        t0 = 0;
        n = 0;
        p = 0;
        repeat (40) @(posedge clk_sys);
        prv = sig(s);
        for (k = 0; k < 400 && p == 0; k++) begin
            @(posedge clk_sys);
            #1;
            cur = sig(s);
            if (cur && !prv) begin
                n++;
                if (n == 3) p = k - t0;
                t0 = k;
            end
            prv = cur;
        end
        chk("period", p, e);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        report_and_stop;
    end
    initial begin
        {sys_rst, reg_wr_en, pll_enable, pll_half_output_divide, clock_select_pll} = 5'h10;
        {gpio_pll_output_enable, reg_addr, reg_wr_data, gpio_divide_select} = '0;
        master_prescale = DIV_ONE;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(7'h24, PRESCALE_INT_RST);
        rd(7'h27, FRAC_LOW_RST);
        // Multiplier programmed while the oscillator is stopped
        wr(7'h24, 9'h008);
        wr(7'h25, 9'h1CC);
        wr(7'h26, 9'h093);
        wr(7'h27, 9'h0E9);
        wr(7'h30, 9'h1FF);
        rd(7'h25, 9'h1CC);
        rd(7'h30, READ_NONE);
        chk("ratio_frac", pll_ratio_frac, 24'h0);
        per(0, 4);
        wr(7'h24, 9'h018);
        per(0, 8);
        wr(7'h24, 9'h008);
        master_prescale <= 8'h03;
        per(1, 12);
        master_prescale <= 8'h00;
        per(1, 4);
        pll_enable <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("ratio_frac", pll_ratio_frac, 24'h3126E9);
        chk("ratio_int", pll_ratio_int, 4'h8);
        wr(7'h27, 9'h000);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("ratio_frac", pll_ratio_frac, 24'h3126E9);
        clock_select_pll <= 1'b1;
        // Prescale two keeps the oscillator in band for a 256x master clock
        master_prescale <= DIV_TWO;
        per(1, 16);
        pll_half_output_divide <= 1'b1;
        per(1, 8);
        pll_half_output_divide <= 1'b0;
        gpio_pll_output_enable <= 1'b1;
        for (i = 0; i < 4; i++) begin
            gpio_divide_select <= i[1:0];
            per(2, 8 * (i + 1));
        end
        chk("pin_oe_n", multipurpose_select_pin_oe_n, 1'b0);
        // Disable before the second reset so no edge straddles it
        pll_enable <= 1'b0;
        gpio_pll_output_enable <= 1'b0;
        reg_addr <= 7'h00;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(7'h25, FRAC_HIGH_RST);
        chk("pin_oe_n", multipurpose_select_pin_oe_n, 1'b1);
        report_and_stop;
    end
endmodule
